//--- sbcsm_pkg.sv
/*
 Shared types and constants for the two-bank synchronous DRAM per-bank
 command state machine. Assumes a single 250 MHz clock domain.
*/
// Summary of operation
// - Idle no-op commands idle; low enable powers down
// - Read burst runs to end, then row active
// - Burst terminate ends read; row stays open
// - New read restarts burst at new column
// - Write during read starts write burst
// - Precharge during read stops, bank precharges
// - Write burst completes, then write recovery
// - Burst terminate ends write; row active
// - Read during write starts read burst
// - New write restarts write at new column
// - Precharge during write stops, bank precharges
// - Autoclose read finishes, then precharges itself
// - Power-down on enable fall, held while low
// - Read data stops latency after terminate
// - Precharging bank idles after precharge time
package sbcsm_pkg;

    // Command encoding: inverted {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        SBCSM_CMD_NOP = 3'h0,
        SBCSM_CMD_TERM = 3'h1,
        SBCSM_CMD_RD = 3'h2,
        SBCSM_CMD_WR = 3'h3,
        SBCSM_CMD_OPEN = 3'h4,
        SBCSM_CMD_PRE = 3'h5,
        SBCSM_CMD_REF = 3'h6,
        SBCSM_CMD_LOAD = 3'h7
    } sbcsm_cmd_e;

    // Gray coded along idle, active, read, write, autoclose, precharge
    typedef enum logic [2:0] {
        SBCSM_IDLE = 3'h0,
        SBCSM_ACTIVE = 3'h1,
        SBCSM_READ = 3'h3,
        SBCSM_WRITE = 3'h2,
        SBCSM_READ_AC = 3'h6,
        SBCSM_PRECHG = 3'h7,
        SBCSM_WRECOV = 3'h5,
        SBCSM_REFRESH = 3'h4
    } sbcsm_state_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bank_sel;
        logic a10;
        logic [7:0] column;
    } sbcsm_cmd_s;

    localparam int CLK_PERIOD_NS = 4;
    localparam int TRP_NS = 20;
    localparam int TWR_NS = 20;
    localparam int TRC_NS = 80;
    localparam int TRP_CYC = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TWR_CYC = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRC_CYC = (TRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam int CL_W = 2;
    localparam int BL_W = 4;
    localparam logic [CL_W-1:0] CAS_LAT_RST = 2'h2;
    localparam logic [BL_W-1:0] BURST_LEN_RST = 4'h4;
    localparam int BANK_CNT = 2;

endpackage

//--- sbcsm_bank.sv
/*
 One bank's command state machine. Assumes the decoded command and its
 bank hit are presented synchronous to clk; power-down handled outside.
*/
`timescale 1ns/1ns
module sbcsm_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Decoded command for this bank
    input wire logic cmd_valid,
    input sbcsm_pkg::sbcsm_cmd_e cmd,
    input wire logic cmd_hit,
    input wire logic cmd_autoclose,
    input wire logic [7:0] cmd_column,
    input wire logic [3:0] burst_len,
    // State
    output sbcsm_pkg::sbcsm_state_e state,
    output logic [7:0] column,
    output logic beat
);

    sbcsm_pkg::sbcsm_state_e state_reg;
    sbcsm_pkg::sbcsm_state_e state_next;
    logic [sbcsm_pkg::CNT_W-1:0] cnt_reg;
    logic [sbcsm_pkg::CNT_W-1:0] cnt_next;
    logic [7:0] col_reg;
    logic [7:0] col_next;
    logic last_beat;
    logic col_cmd;

    assign state = state_reg;
    assign column = col_reg;
    assign beat = (state_reg == sbcsm_pkg::SBCSM_READ)
        || (state_reg == sbcsm_pkg::SBCSM_WRITE)
        || (state_reg == sbcsm_pkg::SBCSM_READ_AC);
    assign last_beat = (cnt_reg == 8'h01);
    assign col_cmd = cmd_valid && cmd_hit
        && ((cmd == sbcsm_pkg::SBCSM_CMD_RD)
        || (cmd == sbcsm_pkg::SBCSM_CMD_WR));

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
        col_next = beat ? col_reg + 8'h01 : col_reg;
        case (state_reg)
            sbcsm_pkg::SBCSM_IDLE: begin
                if (cmd_valid && cmd_hit
                        && cmd == sbcsm_pkg::SBCSM_CMD_OPEN) begin
                    state_next = sbcsm_pkg::SBCSM_ACTIVE;
                end else if (cmd_valid
                        && cmd == sbcsm_pkg::SBCSM_CMD_REF) begin
                    state_next = sbcsm_pkg::SBCSM_REFRESH;
                    cnt_next = 8'(sbcsm_pkg::TRC_CYC);
                end
            end
            sbcsm_pkg::SBCSM_ACTIVE: begin
                if (cmd_valid && cmd_hit
                        && cmd == sbcsm_pkg::SBCSM_CMD_PRE) begin
                    state_next = sbcsm_pkg::SBCSM_PRECHG;
                    cnt_next = 8'(sbcsm_pkg::TRP_CYC);
                end
            end
            sbcsm_pkg::SBCSM_READ: begin
                if (cmd_valid && cmd == sbcsm_pkg::SBCSM_CMD_TERM) begin
                    state_next = sbcsm_pkg::SBCSM_ACTIVE;
                end else if (cmd_valid && cmd_hit
                        && cmd == sbcsm_pkg::SBCSM_CMD_PRE) begin
                    state_next = sbcsm_pkg::SBCSM_PRECHG;
                    cnt_next = 8'(sbcsm_pkg::TRP_CYC);
                end else if (!col_cmd && last_beat) begin
                    state_next = sbcsm_pkg::SBCSM_ACTIVE;
                end
            end
            sbcsm_pkg::SBCSM_WRITE: begin
                if (cmd_valid && cmd == sbcsm_pkg::SBCSM_CMD_TERM) begin
                    state_next = sbcsm_pkg::SBCSM_ACTIVE;
                end else if (cmd_valid && cmd_hit
                        && cmd == sbcsm_pkg::SBCSM_CMD_PRE) begin
                    state_next = sbcsm_pkg::SBCSM_PRECHG;
                    cnt_next = 8'(sbcsm_pkg::TRP_CYC);
                end else if (!col_cmd && last_beat) begin
                    state_next = sbcsm_pkg::SBCSM_WRECOV;
                    cnt_next = 8'(sbcsm_pkg::TWR_CYC);
                end
            end
            sbcsm_pkg::SBCSM_READ_AC: begin
                if (last_beat) begin
                    state_next = sbcsm_pkg::SBCSM_PRECHG;
                    cnt_next = 8'(sbcsm_pkg::TRP_CYC);
                end
            end
            sbcsm_pkg::SBCSM_WRECOV: begin
                if (!col_cmd && last_beat) begin
                    state_next = sbcsm_pkg::SBCSM_ACTIVE;
                end
            end
            sbcsm_pkg::SBCSM_PRECHG, sbcsm_pkg::SBCSM_REFRESH: begin
                if (last_beat) begin
                    state_next = sbcsm_pkg::SBCSM_IDLE;
                end
            end
            default: begin
                state_next = sbcsm_pkg::SBCSM_IDLE;
            end
        endcase
        // Column commands start or restart bursts in open-row states except autoclose read
        if (col_cmd && (state_reg == sbcsm_pkg::SBCSM_ACTIVE
                || state_reg == sbcsm_pkg::SBCSM_READ
                || state_reg == sbcsm_pkg::SBCSM_WRITE
                || state_reg == sbcsm_pkg::SBCSM_WRECOV)) begin
            if (cmd == sbcsm_pkg::SBCSM_CMD_RD) begin
                state_next = cmd_autoclose ? sbcsm_pkg::SBCSM_READ_AC
                    : sbcsm_pkg::SBCSM_READ;
            end else begin
                state_next = sbcsm_pkg::SBCSM_WRITE;
            end
            cnt_next = {4'h0, burst_len};
            col_next = cmd_column;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= sbcsm_pkg::SBCSM_IDLE;
            cnt_reg <= 8'h00;
            col_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            col_reg <= col_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_term_read_active: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == sbcsm_pkg::SBCSM_READ && cmd_valid
        && cmd == sbcsm_pkg::SBCSM_CMD_TERM
        |=> state_reg == sbcsm_pkg::SBCSM_ACTIVE)
        else $error("terminate did not end read");
    a_pre_idle_time: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == sbcsm_pkg::SBCSM_ACTIVE && cmd_valid && cmd_hit
        && cmd == sbcsm_pkg::SBCSM_CMD_PRE
        |=> state_reg == sbcsm_pkg::SBCSM_PRECHG [*5]
        ##1 state_reg == sbcsm_pkg::SBCSM_IDLE)
        else $error("precharge time wrong");
    a_write_recov: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == sbcsm_pkg::SBCSM_WRITE && !cmd_valid && last_beat
        |=> state_reg == sbcsm_pkg::SBCSM_WRECOV)
        else $error("write did not enter recovery");
    a_readac_prechg: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == sbcsm_pkg::SBCSM_READ_AC && last_beat
        |=> state_reg == sbcsm_pkg::SBCSM_PRECHG)
        else $error("autoclose read did not precharge");

endmodule

//--- sbcsm_top.sv
/*
 Two-bank synchronous DRAM command front end: samples the command pins,
 tracks clock enable for power-down, loads mode, runs two bank machines
 and paces read data by the column-strobe latency when it is 2 or 3. Pins are synchronous.
*/
`timescale 1ns/1ns
module sbcsm_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Command pins
    input sbcsm_pkg::sbcsm_cmd_s cmd_pins,
    input wire logic cke,
    input wire logic [10:0] addr_low,
    // Status
    output logic power_down,
    output logic [2:0] bank0_state,
    output logic [2:0] bank1_state,
    output logic read_data_valid,
    output logic [7:0] read_column,
    output logic write_beat,
    output logic illegal_cmd
);

    logic cke_reg;
    logic pd_reg;
    logic [sbcsm_pkg::CL_W-1:0] cas_lat_reg;
    logic [sbcsm_pkg::BL_W-1:0] burst_len_reg;
    logic [3:0] rd_pipe_reg;
    logic [7:0] col_pipe_reg [0:3];
    logic rdv_reg;
    logic [7:0] rcol_reg;
    logic wbeat_reg;
    logic ill_reg;
    logic cmd_valid;
    logic is_nopish;
    sbcsm_pkg::sbcsm_cmd_e cmd;
    sbcsm_pkg::sbcsm_state_e st [0:1];
    logic [7:0] bcol [0:1];
    logic bbeat [0:1];
    logic any_read;
    logic any_write;
    logic [7:0] beat_col;
    logic bank_busy [0:1];

    assign cmd = sbcsm_pkg::sbcsm_cmd_e'({cmd_pins.ras_n, cmd_pins.cas_n,
        cmd_pins.we_n} ^ 3'h7);
    assign is_nopish = cmd_pins.cs_n || cmd == sbcsm_pkg::SBCSM_CMD_NOP
        || cmd == sbcsm_pkg::SBCSM_CMD_TERM;
    // Pins other than enable are ignored while powered down
    assign cmd_valid = !cmd_pins.cs_n && cke_reg && !pd_reg;

    ////////////////////////////////////////////////////////////////////////
    // Power-down: enable falls while both banks idle and no command other than terminate
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cke_reg <= 1'b1;
            pd_reg <= 1'b0;
        end else begin
            cke_reg <= cke;
            if (!cke) begin
                if (cke_reg && is_nopish
                        && st[0] == sbcsm_pkg::SBCSM_IDLE
                        && st[1] == sbcsm_pkg::SBCSM_IDLE) begin
                    pd_reg <= 1'b1;
                end
            end else begin
                pd_reg <= 1'b0;
            end
        end
    end

    // Mode register load from the address lines
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cas_lat_reg <= sbcsm_pkg::CAS_LAT_RST;
            burst_len_reg <= sbcsm_pkg::BURST_LEN_RST;
        end else if (cmd_valid && cmd == sbcsm_pkg::SBCSM_CMD_LOAD
                && st[0] == sbcsm_pkg::SBCSM_IDLE
                && st[1] == sbcsm_pkg::SBCSM_IDLE) begin
            cas_lat_reg <= addr_low[5:4];
            case (addr_low[2:0])
                3'h0: burst_len_reg <= 4'h1;
                3'h1: burst_len_reg <= 4'h2;
                3'h2: burst_len_reg <= 4'h4;
                default: burst_len_reg <= 4'h8;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    for (genvar b = 0; b < sbcsm_pkg::BANK_CNT; b++) begin : g_bank
        logic hit;
        // Precharge with a10 high addresses both banks
        assign hit = (cmd_pins.bank_sel == b[0])
            || (cmd == sbcsm_pkg::SBCSM_CMD_PRE && cmd_pins.a10);
        assign bank_busy[b] = st[b] != sbcsm_pkg::SBCSM_IDLE;
        sbcsm_bank sbcsm_bank_i (
            .clk(clk),
            .sys_rst(sys_rst),
            .cmd_valid(cmd_valid),
            .cmd(cmd),
            .cmd_hit(hit),
            .cmd_autoclose(cmd_pins.a10),
            .cmd_column(cmd_pins.column),
            .burst_len(burst_len_reg),
            .state(st[b]),
            .column(bcol[b]),
            .beat(bbeat[b])
        );
    end

    assign any_read = (bbeat[0] && st[0] != sbcsm_pkg::SBCSM_WRITE)
        || (bbeat[1] && st[1] != sbcsm_pkg::SBCSM_WRITE);
    assign any_write = (st[0] == sbcsm_pkg::SBCSM_WRITE)
        || (st[1] == sbcsm_pkg::SBCSM_WRITE);
    // Column of the bank that is reading, not one that is writing
    assign beat_col = (bbeat[1] && st[1] != sbcsm_pkg::SBCSM_WRITE)
        ? bcol[1] : bcol[0];

    ////////////////////////////////////////////////////////////////////////
    // Read data delayed by the latency when it is 2 or 3; terminate stops it that late too
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pipe_reg <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                col_pipe_reg[i] <= 8'h00;
            end
        end else begin
            rd_pipe_reg <= {rd_pipe_reg[2:0], any_read};
            col_pipe_reg[0] <= beat_col;
            for (int i = 1; i < 4; i++) begin
                col_pipe_reg[i] <= col_pipe_reg[i-1];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdv_reg <= 1'b0;
            rcol_reg <= 8'h00;
            wbeat_reg <= 1'b0;
        end else begin
            rdv_reg <= rd_pipe_reg[cas_lat_reg - 2'h2];
            rcol_reg <= col_pipe_reg[cas_lat_reg - 2'h2];
            wbeat_reg <= any_write;
        end
    end

    // Flags commands that the current state forbids
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ill_reg <= 1'b0;
        end else begin
            ill_reg <= 1'b0;
            if (cmd_valid) begin
                case (cmd)
                    sbcsm_pkg::SBCSM_CMD_REF,
                    sbcsm_pkg::SBCSM_CMD_LOAD:
                        ill_reg <= bank_busy[0] || bank_busy[1];
                    sbcsm_pkg::SBCSM_CMD_OPEN:
                        ill_reg <= bank_busy[cmd_pins.bank_sel];
                    sbcsm_pkg::SBCSM_CMD_RD, sbcsm_pkg::SBCSM_CMD_WR:
                        ill_reg <= st[cmd_pins.bank_sel]
                            == sbcsm_pkg::SBCSM_IDLE;
                    default:
                        ill_reg <= 1'b0;
                endcase
            end
        end
    end

    assign power_down = pd_reg;
    assign bank0_state = st[0];
    assign bank1_state = st[1];
    assign read_data_valid = rdv_reg;
    assign read_column = rcol_reg;
    assign write_beat = wbeat_reg;
    assign illegal_cmd = ill_reg;

    ////////////////////////////////////////////////////////////////////////
    a_pd_entry: assert property (@(posedge clk) disable iff (sys_rst)
        cke_reg && !cke && is_nopish && !pd_reg
        && st[0] == sbcsm_pkg::SBCSM_IDLE && st[1] == sbcsm_pkg::SBCSM_IDLE
        |=> power_down)
        else $error("power-down not entered");
    a_pd_exit: assert property (@(posedge clk) disable iff (sys_rst)
        pd_reg && cke |=> !power_down)
        else $error("power-down not left");
    a_read_start: assert property (@(posedge clk) disable iff (sys_rst)
        cmd_valid && cmd == sbcsm_pkg::SBCSM_CMD_RD && !cmd_pins.a10
        && st[cmd_pins.bank_sel] == sbcsm_pkg::SBCSM_ACTIVE
        |=> st[0] == sbcsm_pkg::SBCSM_READ
        || st[1] == sbcsm_pkg::SBCSM_READ)
        else $error("read did not start");
    a_rd_latency: assert property (@(posedge clk) disable iff (sys_rst)
        cas_lat_reg == 2'h2 && any_read |-> ##2 read_data_valid)
        else $error("read latency wrong");

endmodule

//--- sbcsm_ctrl_model.sv
/*
 Behavioural memory controller that drives the command pins.
 Assumes the bench sets its request lines just after a rising edge.
*/
`timescale 1ns/1ns
module sbcsm_ctrl_model (
    // Clock
    input wire logic clk,
    // Request from the bench
    input wire logic [3:0] req_op,
    input wire logic req_bank,
    input wire logic req_a10,
    input wire logic [7:0] req_col,
    input wire logic req_cke,
    input wire logic allow_illegal,
    // Observed bank states
    input wire logic [2:0] bank0_state,
    input wire logic [2:0] bank1_state,
    // Device pins
    output sbcsm_pkg::sbcsm_cmd_s cmd_pins,
    output logic cke
);
    logic toggle_reg = 1'b0;
    logic [2:0] tgt;
    logic stop;

    ////////////////////////////////////////////////////////////////////////
    // Ignored lines change every cycle while deselected
    always_ff @(posedge clk) begin
        toggle_reg <= ~toggle_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Commands the controller must never send become no-ops
    always_comb begin
        tgt = req_bank ? bank1_state : bank0_state;
        stop = 1'b0;
        if (req_op == 4'h4 && tgt != 3'h0) begin
            stop = 1'b1;
        end
        if (req_op[3:1] == 3'h3 && (bank0_state | bank1_state) != 3'h0) begin
            stop = 1'b1;
        end
        if (req_op != 4'h0 && req_op != 4'h8 && tgt == 3'h6) begin
            stop = 1'b1;
        end
        if (allow_illegal) begin
            stop = 1'b0;
        end
    end

    always_comb begin
        cmd_pins.cs_n = (req_op == 4'h8);
        {cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} =
            stop ? 3'h7 : ~req_op[2:0];
        cmd_pins.bank_sel = req_bank;
        cmd_pins.a10 = req_a10;
        cmd_pins.column = req_col;
        if (req_op == 4'h8) begin
            {cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} = {3{toggle_reg}};
            cmd_pins.bank_sel = toggle_reg;
            cmd_pins.a10 = toggle_reg;
            cmd_pins.column = {8{toggle_reg}};
        end
    end

    assign cke = req_cke;
endmodule

//--- sbcsm_top_test.sv
/*
 Self-checking bench for the command front end. Assumes the controller
 model drives the pins and reset leaves CAS latency 2, burst length 4.
*/
`timescale 1ns/1ns
module sbcsm_top_test;
    typedef struct packed {
        logic [3:0] op;
        logic b;
        logic a;
        logic ck;
        logic [2:0] s0;
        logic [2:0] s1;
        logic pd;
    } sbcsm_row_s;
    localparam logic [3:0] C_NOP = 4'h0, C_STOP = 4'h1, C_RD = 4'h2;
    localparam logic [3:0] C_WR = 4'h3, C_OPEN = 4'h4, C_PRE = 4'h5;
    localparam logic [3:0] C_REF = 4'h6, C_LOAD = 4'h7, C_DSL = 4'h8;
    localparam logic [3:0] C_WAIT = 4'h9;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] req_op = 4'h0;
    logic req_bank = 1'b0;
    logic req_a10 = 1'b0;
    logic [7:0] req_col = 8'h00;
    logic req_cke = 1'b1;
    logic allow_illegal = 1'b0;
    logic [10:0] addr_low = 11'h000;
    sbcsm_pkg::sbcsm_cmd_s cmd_pins;
    logic cke, power_down, read_data_valid, write_beat, illegal_cmd;
    logic [2:0] bank0_state, bank1_state;
    logic [7:0] read_column;
    logic [7:0] cols[$];
    sbcsm_row_s rows[$];
    int bad_count = 0;
    int n_tests = 0;
    int wb_n = 0;
    int ill_n = 0;

    sbcsm_ctrl_model sbcsm_ctrl_model_i (.clk(clk), .req_op(req_op),
        .req_bank(req_bank), .req_a10(req_a10), .req_col(req_col),
        .req_cke(req_cke), .allow_illegal(allow_illegal),
        .bank0_state(bank0_state), .bank1_state(bank1_state),
        .cmd_pins(cmd_pins), .cke(cke));
    sbcsm_top sbcsm_top_i (.clk(clk), .sys_rst(sys_rst),
        .cmd_pins(cmd_pins), .cke(cke), .addr_low(addr_low),
        .power_down(power_down), .bank0_state(bank0_state),
        .bank1_state(bank1_state), .read_data_valid(read_data_valid),
        .read_column(read_column), .write_beat(write_beat),
        .illegal_cmd(illegal_cmd));

    initial begin
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        if (read_data_valid === 1'b1) cols.push_back(read_column);
        if (write_beat === 1'b1) wb_n++;
        if (illegal_cmd === 1'b1) ill_n++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic step(input logic [3:0] op, input logic b, input logic a,
                        input logic [7:0] col, input logic ck);
        req_op = op;
        req_bank = b;
        req_a10 = a;
        req_col = col;
        req_cke = ck;
        @(posedge clk);
        #1;
    endtask

    task automatic nops(input int n);
        repeat (n) step(C_NOP, 1'b0, 1'b0, 8'h00, 1'b1);
    endtask

    // Bounded wait for both bank states
    task automatic wait_for(input logic [2:0] s0, input logic [2:0] s1);
        for (int i = 0; i < 40; i++) begin
            if (bank0_state === s0 && bank1_state === s1) break;
            nops(1);
        end
        check({2'h0, bank0_state, bank1_state}, {2'h0, s0, s1});
        if (bank0_state !== s0 || bank1_state !== s1) complete_run();
    endtask

    // Cycles from the read command to the first valid beat
    task automatic lat(input logic [7:0] exp);
        logic [7:0] k;
        for (k = 8'h00; k < 8'h08 && read_data_valid !== 1'b1; k++) nops(1);
        check(k, exp);
        if (k == 8'h08) complete_run();
    endtask

    // Read columns seen: na from a upward, then nb from b upward
    task automatic runs(input logic [7:0] a, input int na,
                        input logic [7:0] b, input int nb);
        check(8'(cols.size()), 8'(na + nb));
        foreach (cols[i]) check(cols[i], i < na ? a + 8'(i) : b + 8'(i - na));
        cols.delete();
    endtask

    task automatic add(input logic [3:0] op, input logic b, input logic a,
        input logic ck, input logic [2:0] s0, input logic [2:0] s1,
        input logic pd);
        rows.push_back('{op, b, a, ck, s0, s1, pd});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        add(C_DSL, 0, 0, 1, 0, 0, 0);
        add(C_STOP, 0, 0, 1, 0, 0, 0);
        add(C_PRE, 0, 0, 1, 0, 0, 0);
        add(C_NOP, 0, 0, 0, 0, 0, 1);
        add(C_OPEN, 0, 0, 0, 0, 0, 1);
        add(C_NOP, 0, 0, 1, 0, 0, 0);
        add(C_OPEN, 0, 0, 1, 1, 0, 0);
        add(C_OPEN, 1, 0, 1, 1, 1, 0);
        add(C_DSL, 0, 0, 1, 1, 1, 0);
        add(C_STOP, 0, 0, 1, 1, 1, 0);
        add(C_RD, 0, 0, 1, 3, 1, 0);
        add(C_RD, 0, 0, 1, 3, 1, 0);
        add(C_STOP, 0, 0, 1, 1, 1, 0);
        add(C_RD, 0, 0, 1, 3, 1, 0);
        add(C_WR, 0, 0, 1, 2, 1, 0);
        add(C_WR, 0, 0, 1, 2, 1, 0);
        add(C_RD, 0, 0, 1, 3, 1, 0);
        add(C_PRE, 0, 0, 1, 7, 1, 0);
        add(C_NOP, 0, 0, 1, 7, 1, 0);
        add(C_STOP, 0, 0, 1, 7, 1, 0);
        add(C_WAIT, 0, 0, 1, 0, 1, 0);
        add(C_WR, 1, 0, 1, 0, 2, 0);
        add(C_STOP, 1, 0, 1, 0, 1, 0);
        add(C_WR, 1, 0, 1, 0, 2, 0);
        add(C_PRE, 1, 0, 1, 0, 7, 0);
        add(C_WAIT, 0, 0, 1, 0, 0, 0);
        add(C_REF, 0, 0, 1, 4, 4, 0);
        add(C_WAIT, 0, 0, 1, 0, 0, 0);
        add(C_OPEN, 0, 0, 1, 1, 0, 0);
        add(C_OPEN, 1, 0, 1, 1, 1, 0);
        add(C_PRE, 0, 1, 1, 7, 7, 0);
        add(C_WAIT, 0, 0, 1, 0, 0, 0);
        add(C_OPEN, 0, 0, 1, 1, 0, 0);
        add(C_RD, 0, 1, 1, 6, 0, 0);
        add(C_WAIT, 0, 0, 1, 7, 0, 0);
        add(C_WAIT, 0, 0, 1, 0, 0, 0);
        add(C_OPEN, 0, 0, 1, 1, 0, 0);
        add(C_WR, 0, 0, 1, 2, 0, 0);
        add(C_WAIT, 0, 0, 1, 5, 0, 0);
        add(C_WAIT, 0, 0, 1, 1, 0, 0);
        add(C_PRE, 0, 0, 1, 7, 0, 0);
        add(C_WAIT, 0, 0, 1, 0, 0, 0);
        repeat (8) @(posedge clk);
        #1;
        check({bank0_state, bank1_state, power_down}, 7'h00);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].op == C_WAIT) begin
                wait_for(rows[i].s0, rows[i].s1);
            end else begin
                step(rows[i].op, rows[i].b, rows[i].a, 8'h00, rows[i].ck);
                check({bank0_state, bank1_state, power_down},
                      {rows[i].s0, rows[i].s1, rows[i].pd});
            end
        end
        // Read bursts: columns, latency, restart, terminate
        cols.delete();
        step(C_OPEN, 0, 0, 8'h00, 1);
        step(C_RD, 0, 0, 8'h05, 1);
        lat(8'h02);
        nops(6);
        runs(8'h05, 4, 8'h00, 0);
        step(C_RD, 0, 0, 8'h10, 1);
        nops(1);
        step(C_RD, 0, 0, 8'h40, 1);
        nops(8);
        runs(8'h10, 2, 8'h40, 4);
        step(C_RD, 0, 0, 8'h80, 1);
        nops(1);
        step(C_STOP, 0, 0, 8'h00, 1);
        nops(6);
        runs(8'h80, 2, 8'h00, 0);
        // Write bursts: full, stopped, cut by a read
        n = wb_n;
        step(C_WR, 0, 0, 8'h00, 1);
        nops(6);
        check(8'(wb_n - n), 8'h04);
        wait_for(3'h1, 3'h0);
        n = wb_n;
        step(C_WR, 0, 0, 8'h00, 1);
        nops(1);
        step(C_STOP, 0, 0, 8'h00, 1);
        nops(4);
        check(8'(wb_n - n), 8'h02);
        n = wb_n;
        step(C_WR, 0, 0, 8'h00, 1);
        nops(1);
        step(C_RD, 0, 0, 8'h30, 1);
        nops(8);
        check(8'(wb_n - n), 8'h02);
        runs(8'h30, 4, 8'h00, 0);
        step(C_PRE, 0, 0, 8'h00, 1);
        wait_for(3'h0, 3'h0);
        // Mode load: latency 3, burst 2
        addr_low = 11'h031;
        step(C_LOAD, 0, 0, 8'h00, 1);
        addr_low = 11'h000;
        step(C_OPEN, 0, 0, 8'h00, 1);
        step(C_RD, 0, 0, 8'h20, 1);
        lat(8'h03);
        nops(6);
        runs(8'h20, 2, 8'h00, 0);
        step(C_PRE, 0, 0, 8'h00, 1);
        wait_for(3'h0, 3'h0);
        // Illegal commands flagged, state kept
        n = ill_n;
        step(C_RD, 0, 0, 8'h00, 1);
        nops(3);
        check({5'h00, bank0_state}, 8'h00);
        check(8'(ill_n - n), 8'h01);
        allow_illegal = 1'b1;
        step(C_OPEN, 0, 0, 8'h00, 1);
        step(C_OPEN, 0, 0, 8'h00, 1);
        nops(3);
        check(8'(ill_n - n), 8'h02);
        allow_illegal = 1'b0;
        step(C_OPEN, 0, 0, 8'h00, 1);
        nops(3);
        check(8'(ill_n - n), 8'h02);
        // Reset in mid-run
        sys_rst = 1'b1;
        #1;
        check({2'h0, bank0_state, bank1_state}, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        step(C_OPEN, 0, 0, 8'h00, 1);
        check({5'h00, bank0_state}, 8'h01);
        complete_run();
    end
endmodule
